/* hdl/pmc_pkg.sv */
// Purpose: shared constants for the enable and supervisor configuration register bank
// Assumes: 100 MHz clock, 8-bit register port
// Notes: offsets are byte subaddresses of the register port
package pmc_pkg;

  // register subaddresses
  localparam logic [7:0] ADDR_KEY = 8'h10;
  localparam logic [7:0] ADDR_ENABLE = 8'h12;
  localparam logic [7:0] ADDR_CONFIG = 8'h13;

  // values after reset
  localparam logic [7:0] KEY_READ_VALUE = 8'h00;
  localparam logic [6:0] ENABLE_RESET = 7'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h48;

  // unlock key value, arbitrary
  localparam logic [7:0] UNLOCK_KEY_DEFAULT = 8'h5a;

  // output_enable_control field positions
  localparam int EN_LINREG = 0;
  localparam int EN_SW_ONE = 1;
  localparam int EN_SW_TWO = 2;
  localparam int EN_SW_THREE = 3;
  localparam int EN_OUT_ONE = 4;
  localparam int EN_OUT_TWO = 5;
  localparam int EN_OUT_THREE = 6;

  // supervisor_io_config field positions
  localparam int CFG_UV_LO = 0;
  localparam int CFG_TIGHT = 2;
  localparam int CFG_POWER_GOOD_DELAY_SEL_LO = 3;
  localparam int CFG_ROUTE = 5;
  localparam int CFG_BUF = 6;
  localparam int CFG_BUTTON_TIME = 7;

  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PG_DELAY0_MS = 10;
  localparam int PG_DELAY1_MS = 20;
  localparam int PG_DELAY2_MS = 50;
  localparam int PG_DELAY3_MS = 150;
  localparam int MS_PER_S = 1000;
  localparam int BUTTON_SHORT_S = 8;
  localparam int BUTTON_LONG_S = 15;
  localparam int BUTTON_SHORT_MS = BUTTON_SHORT_S * MS_PER_S;
  localparam int BUTTON_LONG_MS = BUTTON_LONG_S * MS_PER_S;

endpackage

/* hdl/pmc_regs.sv */
// Purpose: enable and supervisor configuration register bank with pin control
// Assumes: inputs synchronous to MCLK_I, sequencer requests are one-cycle strobes
// Notes: read data stand only in the cycle after the read strobe
//
// What this block does
// - enable bit 6 zero pulls third output low, one releases it
// - warm-reset pin enable high makes third output bit have no pin effect
// - enable bit 5 zero pulls second output low, one releases it in open-drain mode and drives it high in push-pull mode
// - enable bit 4 zero pulls first output low, one releases it
// - route select high makes enable bits 4 and 5 have no effect
// - enable bits 3..0 switch load switches three..one and regulator on
// - sequencer updates switch one and regulator enables, overriding software
// - configuration register resets to 0x48
// - config bit 7 picks button reset hold 8 s or 15 s
// - config bit 6 picks second output open-drain or push-pull
// - config bit 5 turns first pin into input steering second output
// - config bits 4-3 delay power-good rise 10/20/50/150 ms only
// - config bit 2 selects tight supervision with over-voltage check
// - reading unlock key register always returns zero
`timescale 1ns/10ps
module pmc_regs #(
  parameter int MS_CYCLES = pmc_pkg::MS_CYCLES,
  parameter logic [7:0] UNLOCK_KEY = pmc_pkg::UNLOCK_KEY_DEFAULT
) (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic WARM_RESET_PIN_ENABLE_I,
  input wire logic SEQ_SWITCH_ONE_WR_I,
  input wire logic SEQ_SWITCH_ONE_VAL_I,
  input wire logic SEQ_REGULATOR_WR_I,
  input wire logic SEQ_REGULATOR_VAL_I,
  input wire logic POWER_GOOD_RAW_I,
  input wire logic BUTTON_N_I,
  input wire logic FIRST_GENERAL_IO_I,
  output logic FIRST_GENERAL_IO_O,
  output logic FIRST_GENERAL_IO_OE_O,
  output logic SECOND_GENERAL_OUTPUT_O,
  output logic SECOND_GENERAL_OUTPUT_OE_O,
  output logic THIRD_GENERAL_OUTPUT_O,
  output logic THIRD_GENERAL_OUTPUT_OE_O,
  output logic LOAD_SWITCH_ONE_ON_O,
  output logic LOAD_SWITCH_TWO_ON_O,
  output logic LOAD_SWITCH_THREE_ON_O,
  output logic LINEAR_REGULATOR_ON_O,
  output logic POWER_GOOD_O,
  output logic BUTTON_RESET_O,
  output logic BUTTON_LONG_HOLD_O,
  output logic TIGHT_SUPERVISION_O,
  output logic [1:0] UNDERVOLTAGE_SEL_O,
  output logic UNLOCKED_O
);

  localparam int TW = $clog2(MS_CYCLES + 1);

  typedef struct packed {
    logic armed;
    logic [6:0] enable;
    logic [7:0] config_r;
    logic [7:0] rdata;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [7:0] pg_cnt;
    logic pg;
    logic [13:0] button_cnt;
    logic button_rst;
    logic io1_o;
    logic io1_oe;
    logic out2_o;
    logic out2_oe;
    logic out3_o;
    logic out3_oe;
  } pmc_state_t;

  pmc_state_t st;
  pmc_state_t next_st;

  // power-good delay in ms ticks for the selected code
  function automatic logic [7:0] pg_target(input logic [1:0] sel);
    logic [7:0] t;
    t = 8'(pmc_pkg::PG_DELAY0_MS);
    unique case (sel)
      2'h0: t = 8'(pmc_pkg::PG_DELAY0_MS);
      2'h1: t = 8'(pmc_pkg::PG_DELAY1_MS);
      2'h2: t = 8'(pmc_pkg::PG_DELAY2_MS);
      2'h3: t = 8'(pmc_pkg::PG_DELAY3_MS);
    endcase
    return t;
  endfunction

  // next state of the whole block
  always_comb begin
    logic wr_enable;
    logic wr_config;
    logic [7:0] pg_tgt;
    logic [13:0] button_tgt;
    logic [6:0] en;
    logic [7:0] cfg;
    wr_enable = 1'b0;
    wr_config = 1'b0;
    pg_tgt = 8'h00;
    button_tgt = 14'h0000;
    en = 7'h00;
    cfg = 8'h00;
    next_st = st;

    // unlock handling: a correct key write arms only the next write, whatever its address
    wr_enable = WR_I && (ADDR_I == pmc_pkg::ADDR_ENABLE) && st.armed;
    wr_config = WR_I && (ADDR_I == pmc_pkg::ADDR_CONFIG) && st.armed;
    if (WR_I) begin
      next_st.armed = (ADDR_I == pmc_pkg::ADDR_KEY) && (WDATA_I == UNLOCK_KEY);
    end

    // software writes, bit 7 of the enable register is dropped
    if (wr_enable) begin
      next_st.enable = WDATA_I[6:0];
    end
    if (wr_config) begin
      next_st.config_r = WDATA_I;
    end

    // sequencer wins over a software write in the same cycle
    if (SEQ_SWITCH_ONE_WR_I) begin
      next_st.enable[pmc_pkg::EN_SW_ONE] = SEQ_SWITCH_ONE_VAL_I;
    end
    if (SEQ_REGULATOR_WR_I) begin
      next_st.enable[pmc_pkg::EN_LINREG] = SEQ_REGULATOR_VAL_I;
    end

    // read data for one cycle only, from the state before this cycle's write
    next_st.rdata = 8'h00;
    if (RD_I) begin
      unique case (ADDR_I)
        pmc_pkg::ADDR_KEY: next_st.rdata = pmc_pkg::KEY_READ_VALUE;
        pmc_pkg::ADDR_ENABLE: next_st.rdata = {1'b0, st.enable};
        pmc_pkg::ADDR_CONFIG: next_st.rdata = st.config_r;
        default: next_st.rdata = 8'h00;
      endcase
    end

    // millisecond enable pulse
    next_st.tick = 1'b0;
    if (st.tick_cnt == TW'(MS_CYCLES - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + TW'(1);
    end

    // power-good: delayed rise, immediate fall
    pg_tgt = pg_target(st.config_r[pmc_pkg::CFG_POWER_GOOD_DELAY_SEL_LO +: 2]);
    if (!POWER_GOOD_RAW_I) begin
      next_st.pg = 1'b0;
      next_st.pg_cnt = 8'h00;
    end else if (st.tick && !st.pg) begin
      if (st.pg_cnt >= pg_tgt - 8'h01) begin
        next_st.pg = 1'b1;
      end else begin
        next_st.pg_cnt = st.pg_cnt + 8'h01;
      end
    end

    // push-button hold timer, active low button
    if (st.config_r[pmc_pkg::CFG_BUTTON_TIME]) begin
      button_tgt = 14'(pmc_pkg::BUTTON_LONG_MS);
    end else begin
      button_tgt = 14'(pmc_pkg::BUTTON_SHORT_MS);
    end
    if (BUTTON_N_I) begin
      next_st.button_rst = 1'b0;
      next_st.button_cnt = 14'h0000;
    end else if (st.tick && !st.button_rst) begin
      if (st.button_cnt >= button_tgt - 14'h0001) begin
        next_st.button_rst = 1'b1;
      end else begin
        next_st.button_cnt = st.button_cnt + 14'h0001;
      end
    end

    // pin control from the current register contents
    en = st.enable;
    cfg = st.config_r;
    next_st.io1_o = 1'b0;
    next_st.io1_oe = 1'b0;
    next_st.out2_o = 1'b0;
    next_st.out2_oe = 1'b0;
    if (cfg[pmc_pkg::CFG_ROUTE]) begin
      // first pin is an input whose level drives the second output
      next_st.io1_oe = 1'b0;
      if (cfg[pmc_pkg::CFG_BUF]) begin
        next_st.out2_o = FIRST_GENERAL_IO_I;
        next_st.out2_oe = 1'b1;
      end else begin
        next_st.out2_oe = !FIRST_GENERAL_IO_I;
      end
    end else begin
      next_st.io1_oe = !en[pmc_pkg::EN_OUT_ONE];
      if (cfg[pmc_pkg::CFG_BUF]) begin
        next_st.out2_o = en[pmc_pkg::EN_OUT_TWO];
        next_st.out2_oe = 1'b1;
      end else begin
        next_st.out2_oe = !en[pmc_pkg::EN_OUT_TWO];
      end
    end
    // third output is released while the pin serves as warm-reset input
    next_st.out3_o = 1'b0;
    if (WARM_RESET_PIN_ENABLE_I) begin
      next_st.out3_oe = 1'b0;
    end else begin
      next_st.out3_oe = !en[pmc_pkg::EN_OUT_THREE];
    end

    // synchronous reset
    if (SRST_I) begin
      next_st = '0;
      next_st.enable = pmc_pkg::ENABLE_RESET;
      next_st.config_r = pmc_pkg::CONFIG_RESET;
    end
  end

  // state register
  always_ff @(posedge MCLK_I) begin
    st <= next_st;
  end

  // outputs straight from the state flops
  assign RDATA_O = st.rdata;
  assign FIRST_GENERAL_IO_O = st.io1_o;
  assign FIRST_GENERAL_IO_OE_O = st.io1_oe;
  assign SECOND_GENERAL_OUTPUT_O = st.out2_o;
  assign SECOND_GENERAL_OUTPUT_OE_O = st.out2_oe;
  assign THIRD_GENERAL_OUTPUT_O = st.out3_o;
  assign THIRD_GENERAL_OUTPUT_OE_O = st.out3_oe;
  assign LOAD_SWITCH_ONE_ON_O = st.enable[pmc_pkg::EN_SW_ONE];
  assign LOAD_SWITCH_TWO_ON_O = st.enable[pmc_pkg::EN_SW_TWO];
  assign LOAD_SWITCH_THREE_ON_O = st.enable[pmc_pkg::EN_SW_THREE];
  assign LINEAR_REGULATOR_ON_O = st.enable[pmc_pkg::EN_LINREG];
  assign POWER_GOOD_O = st.pg;
  assign BUTTON_RESET_O = st.button_rst;
  assign BUTTON_LONG_HOLD_O = st.config_r[pmc_pkg::CFG_BUTTON_TIME];
  assign TIGHT_SUPERVISION_O = st.config_r[pmc_pkg::CFG_TIGHT];
  assign UNDERVOLTAGE_SEL_O = st.config_r[pmc_pkg::CFG_UV_LO +: 2];
  assign UNLOCKED_O = st.armed;

endmodule

/* verification/pmc_chk.sv */
// Purpose: port checker for the enable and config register bank
// Assumes: single clock MCLK_I, SRST_I synchronous
// Notes: bound onto pmc_regs
`timescale 1ns/10ps
module pmc_chk (
  input wire logic MCLK_I,
  input wire logic SRST_I,
  input wire logic [7:0] ADDR_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic WARM_RESET_PIN_ENABLE_I,
  input wire logic SEQ_SWITCH_ONE_WR_I,
  input wire logic SEQ_SWITCH_ONE_VAL_I,
  input wire logic SEQ_REGULATOR_WR_I,
  input wire logic SEQ_REGULATOR_VAL_I,
  input wire logic POWER_GOOD_RAW_I,
  input wire logic THIRD_GENERAL_OUTPUT_OE_O,
  input wire logic LOAD_SWITCH_ONE_ON_O,
  input wire logic LOAD_SWITCH_TWO_ON_O,
  input wire logic LOAD_SWITCH_THREE_ON_O,
  input wire logic LINEAR_REGULATOR_ON_O,
  input wire logic POWER_GOOD_O,
  input wire logic TIGHT_SUPERVISION_O,
  input wire logic UNLOCKED_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SRST_I);
  // no armed write to the enable register
  sequence s_no_en_wr;
    !(WR_I && UNLOCKED_O && ADDR_I == 8'h12);
  endsequence
  // two cycles without a config write
  sequence s_no_cfg_wr;
    !(WR_I && ADDR_I == 8'h13) [*2];
  endsequence
  property p_key_read;
    RD_I && ADDR_I == 8'h10 |=> RDATA_O == 8'h00;
  endproperty
  property p_rsv_bit;
    RD_I && ADDR_I == 8'h12 |=> !RDATA_O[7];
  endproperty
  property p_warm;
    WARM_RESET_PIN_ENABLE_I [*2] |-> !THIRD_GENERAL_OUTPUT_OE_O;
  endproperty
  property p_lock;
    s_no_en_wr |=> $stable({LOAD_SWITCH_TWO_ON_O, LOAD_SWITCH_THREE_ON_O});
  endproperty
  property p_seq_one;
    SEQ_SWITCH_ONE_WR_I |=> LOAD_SWITCH_ONE_ON_O == $past(SEQ_SWITCH_ONE_VAL_I);
  endproperty
  property p_seq_reg;
    SEQ_REGULATOR_WR_I |=> LINEAR_REGULATOR_ON_O == $past(SEQ_REGULATOR_VAL_I);
  endproperty
  property p_pg_fall;
    !POWER_GOOD_RAW_I |=> !POWER_GOOD_O;
  endproperty
  property p_pg_rise;
    $rose(POWER_GOOD_O) |-> $past(POWER_GOOD_RAW_I, 8);
  endproperty
  property p_tight;
    s_no_cfg_wr |=> $stable(TIGHT_SUPERVISION_O);
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read not zero");
  a_rsv_bit: assert property (p_rsv_bit) else $error("reserved bit set");
  a_warm: assert property (p_warm) else $error("third output driven");
  a_lock: assert property (p_lock) else $error("locked write took");
  a_seq_one: assert property (p_seq_one) else $error("switch one not updated");
  a_seq_reg: assert property (p_seq_reg) else $error("regulator not updated");
  a_pg_fall: assert property (p_pg_fall) else $error("power good fall late");
  a_pg_rise: assert property (p_pg_rise) else $error("power good rise early");
  a_tight: assert property (p_tight) else $error("tight changed");
endmodule
bind pmc_regs pmc_chk u_pmc_chk (.MCLK_I, .SRST_I, .ADDR_I, .WR_I, .RD_I, .RDATA_O, .WARM_RESET_PIN_ENABLE_I,
  .SEQ_SWITCH_ONE_WR_I, .SEQ_SWITCH_ONE_VAL_I, .SEQ_REGULATOR_WR_I, .SEQ_REGULATOR_VAL_I, .POWER_GOOD_RAW_I,
  .THIRD_GENERAL_OUTPUT_OE_O, .LOAD_SWITCH_ONE_ON_O, .LOAD_SWITCH_TWO_ON_O, .LOAD_SWITCH_THREE_ON_O,
  .LINEAR_REGULATOR_ON_O, .POWER_GOOD_O, .TIGHT_SUPERVISION_O, .UNLOCKED_O);

/* verification/pmc_pins.sv */
// Purpose: board model of the three general pins
// Assumes: pull-ups on second and third outputs
// Notes: first pin follows an outside driver when released
`timescale 1ns/10ps
module pmc_pins (
  input wire logic io1_o_i,
  input wire logic io1_oe_i,
  input wire logic ext_i,
  input wire logic o2_i,
  input wire logic o2_oe_i,
  input wire logic o3_oe_i,
  output logic l1_o,
  output logic l2_o,
  output logic l3_o
);
  // released second and third lines go to the pull level
  assign l1_o = io1_oe_i ? io1_o_i : ext_i;
  assign l2_o = o2_oe_i ? o2_i : 1'b1;
  assign l3_o = o3_oe_i ? 1'b0 : 1'b1;
endmodule

/* verification/tb.sv */
// Purpose: register and pin test of pmc_regs
// Assumes: sim tick of 4 cycles per ms
// Notes: task uw unlocks before each protected write, task wrr does not
`timescale 1ns/10ps
module tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, warm = 0, s1w = 0, s1v = 0, srw = 0, srv = 0, raw = 0, ext = 1, btn = 1;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdat;
  logic io1_o, io1_oe, o2, o2_oe, o3, o3_oe, ls1, ls2, ls3, lr, pg, bt, blh, tight, unl, l1, l2, l3;
  logic [1:0] uv;
  int errors = 0, checks = 0, n;
  pmc_regs #(.MS_CYCLES(4)) u_pmc_regs (.MCLK_I(clk), .SRST_I(rst), .ADDR_I(addr), .WDATA_I(wd), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdat), .WARM_RESET_PIN_ENABLE_I(warm), .SEQ_SWITCH_ONE_WR_I(s1w),
    .SEQ_SWITCH_ONE_VAL_I(s1v), .SEQ_REGULATOR_WR_I(srw), .SEQ_REGULATOR_VAL_I(srv), .POWER_GOOD_RAW_I(raw),
    .BUTTON_N_I(btn), .FIRST_GENERAL_IO_I(l1), .FIRST_GENERAL_IO_O(io1_o), .FIRST_GENERAL_IO_OE_O(io1_oe),
    .SECOND_GENERAL_OUTPUT_O(o2), .SECOND_GENERAL_OUTPUT_OE_O(o2_oe), .THIRD_GENERAL_OUTPUT_O(o3),
    .THIRD_GENERAL_OUTPUT_OE_O(o3_oe), .LOAD_SWITCH_ONE_ON_O(ls1), .LOAD_SWITCH_TWO_ON_O(ls2),
    .LOAD_SWITCH_THREE_ON_O(ls3), .LINEAR_REGULATOR_ON_O(lr), .POWER_GOOD_O(pg), .BUTTON_RESET_O(bt),
    .BUTTON_LONG_HOLD_O(blh), .TIGHT_SUPERVISION_O(tight), .UNDERVOLTAGE_SEL_O(uv), .UNLOCKED_O(unl));
  pmc_pins u_pmc_pins (.io1_o_i(io1_o), .io1_oe_i(io1_oe), .ext_i(ext), .o2_i(o2), .o2_oe_i(o2_oe),
    .o3_oe_i(o3_oe), .l1_o(l1), .l2_o(l2), .l3_o(l3));
  // free running clock
  initial forever #5 clk = ~clk;
  task automatic cmp(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wrr(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // unlock, write, let pins settle
  task automatic uw(input logic [7:0] a, d);
    wrr(8'h10, pmc_pkg::UNLOCK_KEY_DEFAULT);
    wrr(a, d);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    cmp("rdata", e, rdat);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h13, 8'h48);
    rdc(8'h10, 8'h00);
    wrr(8'h12, 8'hff);
    rdc(8'h12, 8'h00);
    $display("test reset and lock done");
    uw(8'h12, 8'hff);
    rdc(8'h12, 8'h7f);
    cmp("switches", 8'h0f, {ls3, ls2, ls1, lr});
    cmp("pins high", 8'h07, {l3, l2, l1});
    uw(8'h12, 8'h00);
    cmp("pins low", 8'h00, {l3, l2, l1});
    cmp("drive levels", 8'h00, {o3, io1_o});
    wrr(8'h10, pmc_pkg::UNLOCK_KEY_DEFAULT);
    #1;
    cmp("armed", 8'h01, unl);
    wrr(8'h11, 8'h00);
    #1;
    cmp("disarmed", 8'h00, unl);
    @(posedge clk) warm <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cmp("third warm", 8'h01, l3);
    uw(8'h13, 8'h20);
    cmp("route high", 8'h03, {l2, l1});
    @(posedge clk) ext <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    cmp("route low", 8'h00, {l2, io1_oe});
    $display("test pins done");
    uw(8'h12, 8'h20);
    uw(8'h13, 8'h40);
    cmp("push pull", 8'h03, {o2_oe, o2});
    uw(8'h13, 8'h00);
    cmp("open drain", 8'h00, o2_oe);
    uw(8'h13, 8'h87);
    rdc(8'h13, 8'h87);
    cmp("config out", 8'h0f, {blh, tight, uv});
    uw(8'h12, 8'h03);
    @(posedge clk);
    {s1w, s1v, srw, srv} <= 4'b1010;
    @(posedge clk);
    {s1w, srw} <= 2'b00;
    #1;
    cmp("sequencer", 8'h00, {ls1, lr});
    rdc(8'h12, 8'h00);
    $display("test config and sequencer done");
    uw(8'h13, 8'h07);
    cmp("short hold", 8'h00, blh);
    @(posedge clk) btn <= 1'b0;
    n = 0;
    while (bt !== 1'b1 && n < 33000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 33000) begin
      errors++;
      wrap_up();
    end
    cmp("button hold", 8'h01, {7'h00, n >= (pmc_pkg::BUTTON_SHORT_MS - 1) * 4 && n <= pmc_pkg::BUTTON_SHORT_MS * 4 + 4});
    @(posedge clk) btn <= 1'b1;
    @(posedge clk);
    #1;
    cmp("button release", 8'h00, bt);
    $display("test button done");
    @(posedge clk) raw <= 1'b1;
    n = 0;
    while (pg !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      wrap_up();
    end
    cmp("pg delay", 8'h01, {7'h00, n >= (pmc_pkg::PG_DELAY0_MS - 1) * 4 && n <= pmc_pkg::PG_DELAY0_MS * 4 + 4});
    @(posedge clk) raw <= 1'b0;
    @(posedge clk);
    #1;
    cmp("pg fall", 8'h00, pg);
    $display("test power good done");
    wrap_up();
  end
endmodule
